// file: shared/fault_status_pkg.sv
/*
 * Constants, types and field layouts for the supply and fault status bank.
 * Assumes a 25 MHz clock and a serial front end that delivers one decoded
 * command (address, clear bit) per frame on the same clock.
 */
package fault_status_pkg;

	// Register addresses, 7-bit.
	localparam logic [6:0] ADDR_SUPPLY  = 7'h41;
	localparam logic [6:0] ADDR_THERMAL = 7'h42;
	localparam logic [6:0] ADDR_HISTORY = 7'h43;
	localparam logic [6:0] ADDR_XCVR    = 7'h44;

	// Reset values after power-on and after soft reset.
	localparam logic [7:0] SUPPLY_POR_VAL  = 8'h80;
	localparam logic [7:0] SUPPLY_SOFT_VAL = 8'h00;
	localparam logic [7:0] ZERO_BYTE       = 8'h00;

	// Supply register bit positions.
	localparam int POS_POR       = 7;
	localparam int POS_SW_UV     = 6;
	localparam int POS_SW_OV     = 5;
	localparam int POS_REG2_OT   = 4;
	localparam int POS_REG2_UV   = 3;
	localparam int POS_SHORT     = 2;
	localparam int POS_UV_FS     = 1;
	localparam int POS_MAIN_UV   = 0;

	// History register field codes.
	localparam logic [1:0] HIST_CLEAR   = 2'h0;
	localparam logic [1:0] HIST_FAILURE = 2'h1;
	localparam logic [1:0] HIST_SLEEP   = 2'h2;
	localparam logic [1:0] WD_ONE       = 2'h1;
	localparam logic [1:0] WD_TWO       = 2'h2;

	// Fourth consecutive undervoltage reset, counted from zero.
	localparam logic [1:0] UV_RESET_LAST = 2'h3;

	// Short detection time and its cycle count at the 25 MHz clock.
	localparam int SHORT_TIME_US = 4000;
	localparam int CLOCK_MHZ     = 25;
	localparam int SHORT_CYCLES  = SHORT_TIME_US * CLOCK_MHZ;

	// Operating mode, Gray coded along init, normal, stop, sleep, restart.
	typedef enum logic [2:0] {
		MODE_INIT     = 3'h0,
		MODE_NORMAL   = 3'h1,
		MODE_STOP     = 3'h3,
		MODE_SLEEP    = 3'h2,
		MODE_RESTART  = 3'h6,
		MODE_FAILSAFE = 3'h7
	} mode_t;

	// Decoded serial command.
	typedef struct packed {
		logic       valid;
		logic       clear;
		logic [6:0] addr;
	} cmd_t;

	// Supply detector outputs.
	typedef struct packed {
		logic sw_uv;
		logic sw_ov;
		logic reg2_ot;
		logic reg2_uv;
		logic main_on;
		logic main_below;
		logic main_uv;
		logic main_ov;
		logic uv_reset;
	} supply_evt_t;

	// Watchdog and history events.
	typedef struct packed {
		logic watchdog_failure_counter;
		logic wd_trig_ok;
		logic wd_stopped;
		logic stop_by_fail;
		logic illegal_sleep;
		logic sleep_no_wake;
		logic sleep_entry;
		logic wake_pending;
		logic ov_reset_opt;
	} history_evt_t;

endpackage

// file: verilog/supply_fault_status_bank.sv
/*
 * Sticky status bank for supply, thermal, history and transceiver faults.
 * Assumes all event inputs come from logic on the same clock, as one-cycle
 * pulses unless noted, and that a front end decodes the serial frames.
 */
module supply_fault_status_bank
	import fault_status_pkg::*;
#(
	parameter int SHORT_CNT = SHORT_CYCLES
) (
	input  wire logic         clock,
	input  wire logic         arst_n,
	input  wire logic         ce,
	input  wire logic         soft_reset,
	input  wire cmd_t         cmd,
	input  wire mode_t        mode,
	input  wire logic         reset_released,
	input  wire supply_evt_t  sup,
	input  wire logic [2:0]   thermal_evt,
	input  wire history_evt_t hist,
	input  wire logic [1:0]   cfg,
	input  wire logic         cfg_sel,
	input  wire logic         spi_fail,
	input  wire logic [1:0]   xcvr_code,
	input  wire logic         xcvr_uv,
	output logic [7:0]        rdata_ff,
	output logic              rvalid_ff,
	output logic              fail_output_ff,
	output logic              restart_req_ff,
	output logic              failsafe_req_ff,
	output logic              tx_disable_ff
);

	localparam int CW = $clog2(SHORT_CNT + 2);

	logic [7:0]    supply_ff;
	logic [2:0]    thermal_ff;
	logic [1:0]    hist_code_ff;
	logic [1:0]    wd_cnt_ff;
	logic          wd_frozen_ff;
	logic          spi_flag_ff;
	logic          failure_ff;
	logic [1:0]    xcvr_ff;
	logic          xcvr_uv_ff;
	logic [CW-1:0] short_cnt_ff;
	logic          short_cond_ff;
	logic [1:0]    uv_resets_ff;
	logic          rel_seen_ff;
	logic          wd_first_ff;
	logic [7:0]    nxt_supply;
	logic [7:0]    sup_set;
	logic          clr_sup;
	logic          clr_therm;
	logic          clr_hist;
	logic          clr_xcvr;
	logic          sleep_off;
	logic          uv_update;
	logic          short_hit;
	logic          uv_fs_hit;
	logic [1:0]    wd_limit;
	logic          wd_reach;
	logic          fail_act;
	logic          wd_restart_only;

	// Host clear strobes per register.
	always_comb begin
		clr_sup   = cmd.valid & cmd.clear & (cmd.addr == ADDR_SUPPLY);
		clr_therm = cmd.valid & cmd.clear & (cmd.addr == ADDR_THERMAL);
		clr_hist  = cmd.valid & cmd.clear & (cmd.addr == ADDR_HISTORY);
		clr_xcvr  = cmd.valid & cmd.clear & (cmd.addr == ADDR_XCVR);
	end

	// Sleep with the main regulator off masks its flags.
	assign sleep_off = (mode == MODE_SLEEP) & ~sup.main_on;

	// Short timer runs while the regulator is on but below threshold.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			short_cnt_ff  <= '0;
			short_cond_ff <= 1'b0;
		end else if (ce) begin
			if (soft_reset || !sup.main_on || !sup.main_below) begin
				short_cnt_ff  <= '0;
				short_cond_ff <= 1'b0;
			end else if (short_cnt_ff != CW'(SHORT_CNT + 1)) begin
				short_cnt_ff <= short_cnt_ff + 1'b1;
			end else begin
				short_cond_ff <= 1'b1;
			end
		end
	end
	assign short_hit = (short_cnt_ff == CW'(SHORT_CNT + 1)) & ~short_cond_ff
		& sup.main_on & sup.main_below;

	// First release of the reset output enables UV updates in init mode.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rel_seen_ff <= 1'b0;
		end else if (ce) begin
			if (soft_reset)
				rel_seen_ff <= 1'b0;
			else if (reset_released)
				rel_seen_ff <= 1'b1;
		end
	end

	// Mode gating of the undervoltage flag.
	always_comb begin
		uv_update = (mode == MODE_NORMAL) | (mode == MODE_STOP)
			| ((mode == MODE_INIT) & rel_seen_ff) | short_cond_ff;
		uv_update = uv_update & ~sleep_off;
	end

	// Consecutive undervoltage resets; normal mode ends the streak.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			uv_resets_ff <= 2'h0;
		end else if (ce) begin
			if (soft_reset || mode == MODE_NORMAL)
				uv_resets_ff <= 2'h0;
			else if (sup.uv_reset && uv_resets_ff != UV_RESET_LAST)
				uv_resets_ff <= uv_resets_ff + 2'h1;
			else if (sup.uv_reset)
				uv_resets_ff <= 2'h0;
		end
	end
	assign uv_fs_hit = sup.uv_reset & (uv_resets_ff == UV_RESET_LAST);

	// Supply flag set terms.
	always_comb begin
		sup_set               = 8'h00;
		sup_set[POS_SW_UV]    = sup.sw_uv;
		sup_set[POS_SW_OV]    = sup.sw_ov;
		sup_set[POS_REG2_OT]  = sup.reg2_ot;
		sup_set[POS_REG2_UV]  = sup.reg2_uv;
		sup_set[POS_SHORT]    = short_hit & ~sleep_off;
		sup_set[POS_UV_FS]    = uv_fs_hit;
		sup_set[POS_MAIN_UV]  = sup.main_uv & uv_update;
		nxt_supply = (clr_sup ? 8'h00 : supply_ff) | sup_set;
	end

	// Supply status register; only power-on reset sets the POR flag.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			supply_ff <= SUPPLY_POR_VAL;
		else if (ce && soft_reset)
			supply_ff <= SUPPLY_SOFT_VAL;
		else if (ce)
			supply_ff <= nxt_supply;
	end

	// Thermal flags and the fail-safe request from second-level shutdown or the fourth consecutive undervoltage reset.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			thermal_ff      <= 3'h0;
			failsafe_req_ff <= 1'b0;
		end else if (ce) begin
			if (soft_reset)
				thermal_ff <= 3'h0;
			else
				thermal_ff <= (clr_therm ? 3'h0 : thermal_ff)
					| thermal_evt;
			failsafe_req_ff <= thermal_evt[2] | uv_fs_hit;
		end
	end

	// Watchdog limit per configuration: config 2 is code 1.
	always_comb begin
		wd_limit        = (cfg == 2'h1) ? WD_ONE : WD_TWO;
		wd_reach        = hist.watchdog_failure_counter & ~wd_frozen_ff
			& (wd_cnt_ff + 2'h1 >= wd_limit);
		wd_restart_only = hist.watchdog_failure_counter & ~cfg_sel & ~wd_first_ff;
		fail_act        = wd_reach & ~wd_restart_only;
	end

	// Watchdog failure counter, the one self-clearing field.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wd_cnt_ff    <= 2'h0;
			wd_frozen_ff <= 1'b0;
			wd_first_ff  <= 1'b0;
		end else if (ce) begin
			if (soft_reset || hist.wd_trig_ok) begin
				wd_cnt_ff    <= 2'h0;
				wd_frozen_ff <= 1'b0;
			end else if (hist.wd_stopped && !hist.stop_by_fail
				&& !wd_frozen_ff) begin
				wd_cnt_ff <= 2'h0;
			end else if (hist.watchdog_failure_counter && !wd_frozen_ff) begin
				if (wd_cnt_ff < wd_limit)
					wd_cnt_ff <= wd_cnt_ff + 2'h1;
				if (cfg == 2'h1 || cfg == 2'h3)
					wd_frozen_ff <= 1'b1;
			end
			if (soft_reset)
				wd_first_ff <= 1'b0;
			else if (hist.watchdog_failure_counter)
				wd_first_ff <= 1'b1;
		end
	end

	// Fail output pulse and restart request.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fail_output_ff <= 1'b0;
			restart_req_ff <= 1'b0;
		end else if (ce) begin
			fail_output_ff <= fail_act;
			restart_req_ff <= hist.watchdog_failure_counter;
		end
	end

	// History code, failure flag and serial failure flag.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hist_code_ff <= HIST_CLEAR;
			failure_ff   <= 1'b0;
			spi_flag_ff  <= 1'b0;
		end else if (ce) begin
			if (soft_reset) begin
				hist_code_ff <= HIST_CLEAR;
				failure_ff   <= 1'b0;
				spi_flag_ff  <= 1'b0;
			end else begin
				if (hist.watchdog_failure_counter || thermal_evt[2] || sup.uv_reset
					|| (sup.main_ov && hist.ov_reset_opt)
					|| hist.illegal_sleep || hist.sleep_no_wake)
					hist_code_ff <= HIST_FAILURE;
				else if (hist.sleep_entry || hist.wake_pending)
					hist_code_ff <= HIST_SLEEP;
				else if (clr_hist)
					hist_code_ff <= HIST_CLEAR;
				failure_ff  <= fail_act | (failure_ff & ~clr_hist);
				spi_flag_ff <= spi_fail | (spi_flag_ff & ~clr_hist);
			end
		end
	end

	// Transceiver fault code and supply flag; the flag holds TX off.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			xcvr_ff       <= 2'h0;
			xcvr_uv_ff    <= 1'b0;
			tx_disable_ff <= 1'b0;
		end else if (ce) begin
			if (soft_reset) begin
				xcvr_ff       <= 2'h0;
				xcvr_uv_ff    <= 1'b0;
				tx_disable_ff <= 1'b0;
			end else begin
				if (xcvr_code != 2'h0)
					xcvr_ff <= xcvr_code;
				else if (clr_xcvr)
					xcvr_ff <= 2'h0;
				xcvr_uv_ff    <= xcvr_uv | (xcvr_uv_ff & ~clr_xcvr);
				tx_disable_ff <= xcvr_uv | (xcvr_uv_ff & ~clr_xcvr);
			end
		end
	end

	// Read path returns the value before any clear; unmapped reads zero.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff  <= ZERO_BYTE;
			rvalid_ff <= 1'b0;
		end else if (ce) begin
			rvalid_ff <= cmd.valid;
			if (cmd.valid) begin
				unique case (cmd.addr)
					ADDR_SUPPLY:  rdata_ff <= supply_ff;
					ADDR_THERMAL: rdata_ff <= {5'h00, thermal_ff};
					ADDR_HISTORY: rdata_ff <= {hist_code_ff, 2'h0, wd_cnt_ff,
						spi_flag_ff, failure_ff};
					ADDR_XCVR:    rdata_ff <= {5'h00, xcvr_ff, xcvr_uv_ff};
					default:      rdata_ff <= ZERO_BYTE;
				endcase
			end
		end
	end

	// Checks on the logic above.
	a_set_beats_clr: assert property (@(posedge clock) disable iff (!arst_n)
		ce && !soft_reset && clr_sup && sup.sw_uv
		|=> supply_ff[POS_SW_UV])
		else $error("supply event lost to a clear");
	a_shutdown_failsafe: assert property (@(posedge clock) disable iff (!arst_n)
		ce && thermal_evt[2] |=> failsafe_req_ff && thermal_ff[2])
		else $error("second-level shutdown without fail-safe request");
	a_therm_sticky: assert property (@(posedge clock) disable iff (!arst_n)
		ce && !soft_reset && !clr_therm && thermal_ff[1]
		|=> thermal_ff[1])
		else $error("thermal flag dropped without clear");
	a_uv_restart: assert property (@(posedge clock) disable iff (!arst_n)
		ce && !soft_reset && mode == MODE_RESTART && !short_cond_ff
		&& clr_sup |=> !supply_ff[POS_MAIN_UV])
		else $error("undervoltage flag set in restart mode");
	a_wd_no_three: assert property (@(posedge clock) disable iff (!arst_n)
		wd_cnt_ff != 2'h3)
		else $error("watchdog counter reached three");
	a_wd_trig_clr: assert property (@(posedge clock) disable iff (!arst_n)
		ce && hist.wd_trig_ok |=> wd_cnt_ff == 2'h0 && !wd_frozen_ff)
		else $error("watchdog counter kept after good trigger");
	a_fail_flag: assert property (@(posedge clock) disable iff (!arst_n)
		fail_output_ff && !$past(soft_reset) |-> failure_ff)
		else $error("fail output without failure flag");
	a_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
		ce && cmd.valid && cmd.addr == ADDR_THERMAL
		|=> rvalid_ff && rdata_ff[7:3] == 5'h00)
		else $error("reserved thermal bits read nonzero");
	a_tx_disable: assert property (@(posedge clock) disable iff (!arst_n)
		ce && !soft_reset && xcvr_uv |=> tx_disable_ff && xcvr_uv_ff)
		else $error("transceiver undervoltage did not disable transmit");
	a_short_time: assert property (@(posedge clock) disable iff (!arst_n)
		ce && !soft_reset && short_hit && mode != MODE_SLEEP
		|=> supply_ff[POS_SHORT] && short_cond_ff)
		else $error("short not flagged after timeout");

endmodule

// file: sim/host_link_model.sv
/*
 * Host side of the status link: issues read and clear frames one at a time.
 * Assumes the bank answers with rvalid one cycle after it takes a frame.
 */
module host_link_model
	import fault_status_pkg::*;
(
	input  wire logic       clock,
	output cmd_t            cmd,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	// The link starts idle with no frame pending.
	initial cmd = cmd_t'(9'h000);

	// One frame; a missing answer comes back unknown so it cannot match.
	task automatic access(input logic clr, input logic [6:0] addr,
		output logic [7:0] data);
		@(negedge clock);
		cmd = {1'b1, clr, addr};
		@(negedge clock);
		data = rvalid ? rdata : 8'hxx;
		cmd = {1'b0, ~clr, ~addr};
	endtask
endmodule

// file: sim/test_supply_fault_status_bank.sv
/*
 * Self-checking bench for the status bank with a short short-detect count.
 * Assumes the host model answers each frame within one cycle.
 */
module test_supply_fault_status_bank import fault_status_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SHORT = 20;
	logic         clock, arst_n, ce, soft_reset, reset_released;
	logic         cfg_sel, spi_fail, xcvr_uv, rvalid_ff, fail_output_ff;
	logic         restart_req_ff, failsafe_req_ff, tx_disable_ff;
	logic [7:0]   rdata_ff;
	logic [2:0]   thermal_evt;
	logic [1:0]   cfg, xcvr_code;
	cmd_t         cmd;
	mode_t        mode;
	supply_evt_t  sup;
	history_evt_t hist;
	int           failures, comparisons;

	supply_fault_status_bank #(.SHORT_CNT(SHORT))
		supply_fault_status_bank_inst (
		.clock(clock), .arst_n(arst_n), .ce(ce), .soft_reset(soft_reset),
		.cmd(cmd), .mode(mode), .reset_released(reset_released),
		.sup(sup), .thermal_evt(thermal_evt), .hist(hist), .cfg(cfg),
		.cfg_sel(cfg_sel), .spi_fail(spi_fail), .xcvr_code(xcvr_code),
		.xcvr_uv(xcvr_uv), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
		.fail_output_ff(fail_output_ff), .restart_req_ff(restart_req_ff),
		.failsafe_req_ff(failsafe_req_ff), .tx_disable_ff(tx_disable_ff));
	host_link_model host_link_model_inst (
		.clock(clock), .cmd(cmd), .rdata(rdata_ff), .rvalid(rvalid_ff));

	// The clock toggles every 20 ns, a period of 40 ns.
	always #20 clock = ~clock;

	task automatic nx;
		@(negedge clock);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t ns: got %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_link_model_inst.access(1'b0, a, d);
		chk(d, e);
	endtask
	task automatic clr(input logic [6:0] a);
		logic [7:0] d;
		host_link_model_inst.access(1'b1, a, d);
	endtask
	task automatic sp(input logic [8:0] v);
		sup = supply_evt_t'(v);
		nx;
		sup = '0;
	endtask
	task automatic hp(input logic [8:0] v);
		hist = history_evt_t'(v);
		nx;
		hist = '0;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic t_reset_values;
		rd(ADDR_SUPPLY, 8'h80);
		rd(ADDR_THERMAL, 8'h00);
		rd(ADDR_HISTORY, 8'h00);
		rd(ADDR_XCVR, 8'h00);
		clr(7'h45);
		rd(7'h40, 8'h00);
	endtask
	task automatic t_uv_gating;
		mode = MODE_RESTART;
		sp(9'h004);
		rd(ADDR_SUPPLY, 8'h80);
		mode = MODE_INIT;
		sp(9'h004);
		rd(ADDR_SUPPLY, 8'h80);
		reset_released = 1'b1;
		nx;
		reset_released = 1'b0;
		sp(9'h004);
		rd(ADDR_SUPPLY, 8'h81);
		clr(ADDR_SUPPLY);
		rd(ADDR_SUPPLY, 8'h00);
		mode = MODE_SLEEP;
		sp(9'h00e);
		rd(ADDR_SUPPLY, 8'h00);
		mode = MODE_RESTART;
		for (int i = 0; i < 4; i++) begin
			sp(9'h001);
			chk(failsafe_req_ff, i == 3);
			nx;
		end
		rd(ADDR_SUPPLY, 8'h02);
		clr(ADDR_SUPPLY);
	endtask
	task automatic t_supply_bits;
		int src[5] = '{8, 7, 6, 5, 2};
		int dst[5] = '{6, 5, 4, 3, 0};
		mode = MODE_NORMAL;
		for (int i = 0; i < 5; i++) begin
			sp(9'h001 << src[i]);
			rd(ADDR_SUPPLY, 8'h01 << dst[i]);
			clr(ADDR_SUPPLY);
		end
		sup.main_on = 1'b1;
		sup.main_below = 1'b1;
		repeat (SHORT - 1) nx;
		rd(ADDR_SUPPLY, 8'h00);
		rd(ADDR_SUPPLY, 8'h04);
		sup = '0;
		rd(ADDR_SUPPLY, 8'h04);
		clr(ADDR_SUPPLY);
		// A supply event in the very cycle of a clear must survive it.
		fork
			clr(ADDR_SUPPLY);
			begin
				nx;
				sup.sw_uv = 1'b1;
				nx;
				sup.sw_uv = 1'b0;
			end
		join
		rd(ADDR_SUPPLY, 8'h40);
		clr(ADDR_SUPPLY);
	endtask
	task automatic t_thermal;
		thermal_evt = 3'h4;
		nx;
		thermal_evt = 3'h0;
		chk(failsafe_req_ff, 1'b1);
		rd(ADDR_THERMAL, 8'h04);
		thermal_evt = 3'h3;
		nx;
		thermal_evt = 3'h0;
		rd(ADDR_THERMAL, 8'h07);
		rd(ADDR_HISTORY, 8'h40);
		clr(ADDR_THERMAL);
		clr(ADDR_HISTORY);
		rd(ADDR_THERMAL, 8'h00);
	endtask
	task automatic t_history;
		logic [8:0] ev[4] = '{9'h010, 9'h008, 9'h006, 9'h014};
		logic [7:0] ex[4] = '{8'h40, 8'h40, 8'h80, 8'h40};
		for (int i = 0; i < 4; i++) begin
			hp(ev[i]);
			rd(ADDR_HISTORY, ex[i]);
			clr(ADDR_HISTORY);
		end
		hist.ov_reset_opt = 1'b1;
		sp(9'h002);
		hist = '0;
		rd(ADDR_HISTORY, 8'h40);
		clr(ADDR_HISTORY);
		spi_fail = 1'b1;
		nx;
		spi_fail = 1'b0;
		rd(ADDR_HISTORY, 8'h02);
		fork
			clr(ADDR_HISTORY);
			begin
				nx;
				spi_fail = 1'b1;
				nx;
				spi_fail = 1'b0;
			end
		join
		rd(ADDR_HISTORY, 8'h02);
		clr(ADDR_HISTORY);
		rd(ADDR_HISTORY, 8'h00);
	endtask
	task automatic t_watchdog;
		soft_reset = 1'b1;
		nx;
		soft_reset = 1'b0;
		rd(ADDR_SUPPLY, 8'h00);
		hp(9'h100);
		chk({restart_req_ff, fail_output_ff}, 8'h02);
		rd(ADDR_HISTORY, 8'h44);
		cfg_sel = 1'b1;
		hp(9'h100);
		chk(fail_output_ff, 1'b1);
		rd(ADDR_HISTORY, 8'h49);
		hp(9'h100);
		nx;
		hp(9'h060);
		rd(ADDR_HISTORY, 8'h49);
		hp(9'h040);
		rd(ADDR_HISTORY, 8'h41);
		clr(ADDR_HISTORY);
		cfg = 2'h1;
		hp(9'h100);
		chk(fail_output_ff, 1'b1);
		nx;
		hp(9'h100);
		rd(ADDR_HISTORY, 8'h45);
		hp(9'h080);
		rd(ADDR_HISTORY, 8'h41);
		clr(ADDR_HISTORY);
	endtask
	task automatic t_xcvr;
		for (int c = 1; c < 4; c++) begin
			xcvr_code = 2'(c);
			nx;
			xcvr_code = 2'h0;
			rd(ADDR_XCVR, 8'(c << 1));
			clr(ADDR_XCVR);
		end
		xcvr_uv = 1'b1;
		nx;
		xcvr_uv = 1'b0;
		chk(tx_disable_ff, 1'b1);
		rd(ADDR_XCVR, 8'h01);
		clr(ADDR_XCVR);
		nx;
		chk(tx_disable_ff, 1'b0);
	endtask

	// Main sequence: reset for 8 cycles, then every scenario in turn.
	initial begin
		{clock, arst_n, soft_reset, reset_released, spi_fail, xcvr_uv} = '0;
		{thermal_evt, xcvr_code, cfg, cfg_sel} = '0;
		{sup, hist, failures, comparisons} = '0;
		ce = 1'b1;
		mode = MODE_INIT;
		repeat (8) @(posedge clock);
		nx;
		arst_n = 1'b1;
		t_reset_values;
		t_uv_gating;
		t_supply_bits;
		t_thermal;
		t_history;
		t_watchdog;
		t_xcvr;
		give_verdict;
	end

	// Watchdog: the scenarios need well under 1000 cycles.
	initial begin
		#(5000 * 40);
		failures++;
		give_verdict;
	end
endmodule
